// [design/dsio_map.svh]
// constants of the separate-i/o double-rate burst sram block
`ifndef DSIO_MAP_SVH
`define DSIO_MAP_SVH

// ****************************************************************
// geometry
// ****************************************************************
// lanes 4 is the wide part; 2 lanes with word width 18 give the narrow 18-bit part
`define DSIO_ADDR_W 19
`define DSIO_LANES 4
`define DSIO_LANE_W 9
`define DSIO_WORD_W 36

// ****************************************************************
// crossing buffer
// ****************************************************************
`define DSIO_BUF_DEPTH 2
`define DSIO_PTR_W 2
`define DSIO_PTR_ONE 2'h1
`define DSIO_GRAY_FULL 2'h3
`define DSIO_STRAP_HIGH 2'h3

`endif

// [design/dsio_pkg.sv]
// types shared by the burst sram block
package dsio_pkg;
`include "dsio_map.svh"

    typedef logic [`DSIO_WORD_W-1:0] dsio_word_t;
    typedef logic [`DSIO_LANES-1:0] dsio_lanes_t;
    typedef logic [`DSIO_ADDR_W-1:0] dsio_addr_t;
    typedef logic [`DSIO_PTR_W-1:0] dsio_ptr_t;

    typedef struct packed {
        dsio_word_t w1;
        dsio_word_t w0;
    } dsio_pair_t;

    typedef enum logic [1:0] {
        DSIO_OUT_IDLE = 2'h1,
        DSIO_OUT_SEND = 2'h2
    } dsio_out_state_t;
endpackage

// [design/dsio_buf.sv]
// two-entry buffer carrying read bursts between clock domains
`timescale 1ns/10ps
module dsio_buf (
    input wire logic wr_clock,
    input wire logic wr_rst,
    input wire logic wr_ce,
    input wire logic wr_valid,
    output logic wr_ready,
    input dsio_pkg::dsio_pair_t wr_data,
    input wire logic rd_clock,
    input wire logic rd_rst,
    input wire logic rd_ce,
    output logic rd_valid,
    input wire logic rd_ready,
    output dsio_pkg::dsio_pair_t rd_data
);
    import dsio_pkg::*;

    // ****************************************************************
    // storage and pointers
    // ****************************************************************
    dsio_pair_t mem_q [0:`DSIO_BUF_DEPTH-1];
    dsio_ptr_t wbin_q, wgray_q, rbin_q, rgray_q;
    dsio_ptr_t rg_s1_q, rg_s2_q, wg_s1_q, wg_s2_q;
    dsio_ptr_t wbin_d, rbin_d;
    logic push, pop;

    // gray pointers: only one bit moves per step, so a crossing is safe
    assign wbin_d = wbin_q + `DSIO_PTR_ONE;
    assign rbin_d = rbin_q + `DSIO_PTR_ONE;
    assign wr_ready = wgray_q != (rg_s2_q ^ `DSIO_GRAY_FULL);
    assign rd_valid = rgray_q != wg_s2_q;
    assign push = wr_ce && wr_valid && wr_ready;
    assign pop = rd_ce && rd_valid && rd_ready;
    assign rd_data = mem_q[rbin_q[`DSIO_PTR_W-2:0]];

    // ****************************************************************
    // write side
    // ****************************************************************
    always_ff @(posedge wr_clock) begin
        if (push) begin
            mem_q[wbin_q[`DSIO_PTR_W-2:0]] <= wr_data;
        end
    end

    always_ff @(posedge wr_clock) begin
        if (wr_rst) begin
            wbin_q <= '0;
            wgray_q <= '0;
            rg_s1_q <= '0;
            rg_s2_q <= '0;
        end else if (wr_ce) begin
            rg_s1_q <= rgray_q;
            rg_s2_q <= rg_s1_q;
            if (push) begin
                wbin_q <= wbin_d;
                wgray_q <= wbin_d ^ (wbin_d >> 1);
            end
        end
    end

    // ****************************************************************
    // read side
    // ****************************************************************
    always_ff @(posedge rd_clock) begin
        if (rd_rst) begin
            rbin_q <= '0;
            rgray_q <= '0;
            wg_s1_q <= '0;
            wg_s2_q <= '0;
        end else if (rd_ce) begin
            wg_s1_q <= wgray_q;
            wg_s2_q <= wg_s1_q;
            if (pop) begin
                rbin_q <= rbin_d;
                rgray_q <= rbin_d ^ (rbin_d >> 1);
            end
        end
    end
endmodule

// [design/dsio_top.sv]
// separate-i/o double-rate burst sram: command, write and read paths
`timescale 1ns/10ps
module dsio_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic clock_en,
    input wire logic output_timing_pos,
    input wire logic output_timing_neg,
    input wire logic pll_bypass_n,
    input wire logic access_request_n,
    input wire logic direction_select,
    input dsio_pkg::dsio_addr_t address,
    input dsio_pkg::dsio_lanes_t byte_lane_enable_n,
    input dsio_pkg::dsio_word_t write_data,
    output dsio_pkg::dsio_word_t read_data,
    output logic read_data_oe,
    output logic read_ready
);
    import dsio_pkg::*;

    // ****************************************************************
    // command decode
    // ****************************************************************
    logic rs_v_q, wph1_q, wph2_q, hold_v_q;
    logic buf_wr_ready;
    dsio_addr_t rs_addr_q, a1_q, a2_q, hold_addr_q;
    wire start_op = !access_request_n;
    wire wr_cmd = start_op && !direction_select;
    wire rd_cmd = start_op && direction_select && read_ready;
    // one read every other cycle: the buffer can then never be overrun
    assign read_ready = buf_wr_ready && !rs_v_q;

    // ****************************************************************
    // k-bar edge capture
    // ****************************************************************
    // k-bar is taken as the falling edge of k, the two being complements
    dsio_word_t neg_data_q;
    dsio_lanes_t neg_be_n_q;

    always_ff @(negedge clock) begin
        if (rst) begin
            neg_data_q <= '0;
            neg_be_n_q <= '1;
        end else if (clock_en) begin
            neg_data_q <= write_data;
            neg_be_n_q <= byte_lane_enable_n;
        end
    end

    // ****************************************************************
    // lane masks
    // ****************************************************************
    dsio_word_t in_w0_q, hold_w0_q, hold_w1_q;
    dsio_lanes_t in_be0_n_q, hold_be0_n_q, hold_be1_n_q;
    dsio_word_t hold_m0, hold_m1, in_m0, in_m1;

    genvar gl;
    generate
        for (gl = 0; gl < `DSIO_LANES; gl++) begin : g_lane
            assign hold_m0[gl*`DSIO_LANE_W +: `DSIO_LANE_W] =
                {`DSIO_LANE_W{!hold_be0_n_q[gl]}};
            assign hold_m1[gl*`DSIO_LANE_W +: `DSIO_LANE_W] =
                {`DSIO_LANE_W{!hold_be1_n_q[gl]}};
            assign in_m0[gl*`DSIO_LANE_W +: `DSIO_LANE_W] =
                {`DSIO_LANE_W{!in_be0_n_q[gl]}};
            assign in_m1[gl*`DSIO_LANE_W +: `DSIO_LANE_W] =
                {`DSIO_LANE_W{!neg_be_n_q[gl]}};
        end
    endgenerate

    // ****************************************************************
    // array and posted write
    // ****************************************************************
    dsio_pair_t mem_q [0:(1<<`DSIO_ADDR_W)-1];
    dsio_pair_t cur_pair, commit_pair;
    wire commit_en = clock_en && wph2_q && hold_v_q;

    assign cur_pair = mem_q[hold_addr_q];
    // masked merge keeps unselected bytes unchanged
    assign commit_pair.w0 = (cur_pair.w0 & ~hold_m0) |
        (hold_w0_q & hold_m0);
    assign commit_pair.w1 = (cur_pair.w1 & ~hold_m1) |
        (hold_w1_q & hold_m1);

    always_ff @(posedge clock) begin
        if (commit_en) begin
            mem_q[hold_addr_q] <= commit_pair;
        end
    end

    // ****************************************************************
    // write collection
    // ****************************************************************
    // a write is complete two edges after its command; the finished
    // burst then displaces the older posted one into the array
    always_ff @(posedge clock) begin
        if (rst) begin
            wph1_q <= 1'b0;
            wph2_q <= 1'b0;
            hold_v_q <= 1'b0;
            a1_q <= '0;
            a2_q <= '0;
            hold_addr_q <= '0;
            in_w0_q <= '0;
            in_be0_n_q <= '1;
            hold_w0_q <= '0;
            hold_w1_q <= '0;
            hold_be0_n_q <= '1;
            hold_be1_n_q <= '1;
        end else if (clock_en) begin
            wph1_q <= wr_cmd;
            wph2_q <= wph1_q;
            if (wr_cmd) begin
                a1_q <= address;
            end
            if (wph1_q) begin
                a2_q <= a1_q;
                in_w0_q <= write_data;
                in_be0_n_q <= byte_lane_enable_n;
            end
            if (wph2_q) begin
                hold_v_q <= 1'b1;
                hold_addr_q <= a2_q;
                hold_w0_q <= in_w0_q;
                hold_be0_n_q <= in_be0_n_q;
                hold_w1_q <= neg_data_q;
                hold_be1_n_q <= neg_be_n_q;
            end
        end
    end

    // ****************************************************************
    // read fetch with forwarding
    // ****************************************************************
    dsio_pair_t arr_pair, fwd1_pair, rd_pair;
    wire hit_hold = hold_v_q && (hold_addr_q == rs_addr_q);
    wire hit_in = wph2_q && (a2_q == rs_addr_q);

    // posted and half-collected writes are newer than the array
    assign arr_pair = mem_q[rs_addr_q];
    assign fwd1_pair.w0 = hit_hold ?
        ((arr_pair.w0 & ~hold_m0) | (hold_w0_q & hold_m0)) : arr_pair.w0;
    assign fwd1_pair.w1 = hit_hold ?
        ((arr_pair.w1 & ~hold_m1) | (hold_w1_q & hold_m1)) : arr_pair.w1;
    assign rd_pair.w0 = hit_in ?
        ((fwd1_pair.w0 & ~in_m0) | (in_w0_q & in_m0)) : fwd1_pair.w0;
    assign rd_pair.w1 = hit_in ?
        ((fwd1_pair.w1 & ~in_m1) | (neg_data_q & in_m1)) : fwd1_pair.w1;

    always_ff @(posedge clock) begin
        if (rst) begin
            rs_v_q <= 1'b0;
            rs_addr_q <= '0;
        end else if (clock_en) begin
            rs_v_q <= rd_cmd;
            if (rd_cmd) begin
                rs_addr_q <= address;
            end
        end
    end

    // ****************************************************************
    // single clock strap
    // ****************************************************************
    logic [1:0] st_s1_q, st_s2_q;
    logic rst_d_q, single_q;

    // the strap is watched through reset, so it is settled at release
    always_ff @(posedge clock) begin
        st_s1_q <= {output_timing_pos, output_timing_neg};
        st_s2_q <= st_s1_q;
        rst_d_q <= rst;
    end

    // caught as each reset ends; cannot change until the next reset
    // k times the output side in reset, as c may be parked then
    always_ff @(posedge clock) begin
        if (rst) begin
            single_q <= 1'b1;
        end else if (rst_d_q) begin
            single_q <= st_s2_q == `DSIO_STRAP_HIGH;
        end
    end

    // static between resets, so this mux never glitches in use
    wire out_clock = single_q ? clock : output_timing_pos;

    // ****************************************************************
    // output domain synchronisers
    // ****************************************************************
    logic or_s1_q, out_rst, ce_s1_q, ce_o, pb_s1_q, pb_o;

    always_ff @(posedge out_clock) begin
        or_s1_q <= rst;
        out_rst <= or_s1_q;
        ce_s1_q <= clock_en;
        ce_o <= ce_s1_q;
        pb_s1_q <= pll_bypass_n;
        pb_o <= pb_s1_q;
    end

    // ****************************************************************
    // crossing buffer
    // ****************************************************************
    dsio_pair_t buf_rd_data;
    logic buf_rd_valid;

    dsio_buf u_buf (
        .wr_clock(clock),
        .wr_rst(rst),
        .wr_ce(clock_en),
        .wr_valid(rs_v_q),
        .wr_ready(buf_wr_ready),
        .wr_data(rd_pair),
        .rd_clock(out_clock),
        .rd_rst(out_rst),
        .rd_ce(ce_o),
        .rd_valid(buf_rd_valid),
        .rd_ready(1'b1),
        .rd_data(buf_rd_data)
    );

    // ****************************************************************
    // output sequencer
    // ****************************************************************
    dsio_out_state_t state_q;
    dsio_pair_t pair_q;
    dsio_word_t pos_q, neg_q;
    logic pos_oe_q, neg_oe_q;
    wire sending = state_q == DSIO_OUT_SEND;

    always_ff @(posedge out_clock) begin
        if (out_rst) begin
            state_q <= DSIO_OUT_IDLE;
            pair_q <= '0;
            pos_q <= '0;
            pos_oe_q <= 1'b0;
        end else if (ce_o) begin
            if (buf_rd_valid) begin
                state_q <= DSIO_OUT_SEND;
                pair_q <= buf_rd_data;
            end else begin
                state_q <= DSIO_OUT_IDLE;
            end
            if (pb_o) begin
                pos_q <= pair_q.w1;
                pos_oe_q <= sending;
            end else begin
                pos_q <= buf_rd_data.w0;
                pos_oe_q <= buf_rd_valid;
            end
        end
    end

    always_ff @(negedge out_clock) begin
        if (out_rst) begin
            neg_q <= '0;
            neg_oe_q <= 1'b0;
        end else if (ce_o) begin
            neg_q <= pb_o ? pair_q.w0 : pair_q.w1;
            neg_oe_q <= sending;
        end
    end

    // double-rate output: high half shows the c word, low half c-bar
    assign read_data = out_clock ? pos_q : neg_q;
    assign read_data_oe = out_clock ? pos_oe_q : neg_oe_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_nop_ignored: assert property (@(posedge clock)
        disable iff (rst || !clock_en)
        access_request_n |=> !wph1_q && !rs_v_q)
        else $error("deselect started an operation");

    chk_read_fetch: assert property (@(posedge clock)
        disable iff (rst || !clock_en)
        rd_cmd |=> rs_v_q && rs_addr_q == $past(address))
        else $error("read command not fetched next cycle");

    chk_push_taken: assert property (@(posedge clock)
        disable iff (rst)
        rs_v_q |-> buf_wr_ready)
        else $error("read burst refused by buffer");

    chk_write_hold: assert property (@(posedge clock)
        disable iff (rst || !clock_en)
        wr_cmd ##1 clock_en ##1 clock_en |=> hold_v_q &&
        hold_addr_q == $past(address, 3))
        else $error("write burst not held at its address");

    chk_posted_commit: assert property (@(posedge clock)
        disable iff (rst)
        commit_en |=> mem_q[$past(hold_addr_q)] == $past(commit_pair))
        else $error("posted write not committed");

    chk_all_lanes: assert property (@(posedge clock)
        disable iff (rst)
        commit_en && hold_be0_n_q == '0 |=>
        mem_q[$past(hold_addr_q)].w0 == $past(hold_w0_q))
        else $error("full-lane word not written whole");

    chk_no_lanes: assert property (@(posedge clock)
        disable iff (rst)
        commit_en && hold_be1_n_q == '1 |=>
        mem_q[$past(hold_addr_q)].w1 == $past(cur_pair.w1))
        else $error("masked word altered the array");

    chk_freeze_hold: assert property (@(posedge clock)
        disable iff (rst)
        !clock_en |=> $stable(hold_v_q) && $stable(wph1_q) &&
        $stable(rs_v_q))
        else $error("state moved while clock enable low");

    chk_second_word: assert property (@(posedge out_clock)
        disable iff (out_rst)
        pb_o && sending && ce_o |=> pos_oe_q &&
        pos_q == $past(pair_q.w1))
        else $error("second word not driven on c rise");

    chk_idle_hiz: assert property (@(posedge out_clock)
        disable iff (out_rst)
        pb_o && ce_o && !sending && !buf_rd_valid |=> !pos_oe_q)
        else $error("outputs driven with no read pending");
endmodule

// [tb/dsio_ctl_model.sv]
// controller-side model: output clock source and read word capture
`timescale 1ns/10ps
module dsio_ctl_model #(
    parameter realtime HALF = 3.0
) (
    input wire logic k_clock,
    input wire logic park,
    output logic output_timing_pos,
    output logic output_timing_neg,
    input wire logic read_data_oe,
    input dsio_pkg::dsio_word_t read_data
);
    import dsio_pkg::*;

    dsio_word_t words[$];
    logic run_q;
    // with c parked the words come on the k clock instead
    wire cap_clock = park ? k_clock : output_timing_pos;

    // ****************************************************************
    // output clock pair
    // ****************************************************************
    // free running; the odd start offset keeps it unrelated in phase
    // to the input clock
    initial begin
        run_q = 1'b0;
        #1.3;
        forever #HALF run_q = ~run_q;
    end

    // parked: both high; held so through reset it straps single clock
    assign output_timing_pos = park || run_q;
    // never both high while running, so the strap stays off
    assign output_timing_neg = park || !run_q;

    // ****************************************************************
    // read capture
    // ****************************************************************
    // each word stands one half clock: sample mid-half, both halves
    always @(cap_clock) begin
        #(HALF / 2.0);
        if (read_data_oe === 1'b1) begin
            words.push_back(read_data);
        end
    end
endmodule

// [tb/testbench.sv]
// self-checking bench for the burst sram block
`timescale 1ns/10ps
`include "dsio_map.svh"
`define CHK(got, exp, msg) \
    begin \
        compares++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("wrong value at %0t: %s", $time, msg); \
        end \
    end
module testbench;
    import dsio_pkg::*;

    logic clock, rst, clock_en, pll_bypass_n, park;
    logic access_request_n, direction_select;
    logic output_timing_pos, output_timing_neg, read_data_oe, read_ready;
    dsio_addr_t address;
    dsio_lanes_t byte_lane_enable_n;
    dsio_word_t write_data, read_data;
    int err_count, compares, cycles;
    dsio_pair_t model [dsio_addr_t];

    // ****************************************************************
    // clock, instances, timeout
    // ****************************************************************
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    dsio_top u_dsio_top (
        .clock(clock), .rst(rst), .clock_en(clock_en),
        .output_timing_pos(output_timing_pos),
        .output_timing_neg(output_timing_neg),
        .pll_bypass_n(pll_bypass_n), .access_request_n(access_request_n),
        .direction_select(direction_select), .address(address),
        .byte_lane_enable_n(byte_lane_enable_n), .write_data(write_data),
        .read_data(read_data), .read_data_oe(read_data_oe),
        .read_ready(read_ready)
    );

    dsio_ctl_model u_dsio_ctl_model (
        .k_clock(clock), .park(park),
        .output_timing_pos(output_timing_pos),
        .output_timing_neg(output_timing_neg),
        .read_data_oe(read_data_oe), .read_data(read_data)
    );

    // whole run is well under 2000 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            $display("wrong value at %0t: timeout", $time);
            end_of_test();
        end
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic step();
        @(posedge clock);
        #1;
    endtask

    function automatic dsio_word_t merge(dsio_word_t old, dsio_word_t nw,
                                         dsio_lanes_t ln);
        for (int i = 0; i < `DSIO_LANES; i++) begin
            if (!ln[i]) begin
                old[i*`DSIO_LANE_W +: `DSIO_LANE_W] =
                    nw[i*`DSIO_LANE_W +: `DSIO_LANE_W];
            end
        end
        return old;
    endfunction

    // command, then word0 at the next rise, word1 at that fall
    task automatic wr(dsio_addr_t a, dsio_word_t d0, dsio_word_t d1,
                      dsio_lanes_t l0, dsio_lanes_t l1);
        dsio_pair_t p;
        p = model.exists(a) ? model[a] : 'x;
        step();
        access_request_n = 1'b0;
        direction_select = 1'b0;
        address = a;
        step();
        access_request_n = 1'b1;
        write_data = d0;
        byte_lane_enable_n = l0;
        step();
        write_data = d1;
        byte_lane_enable_n = l1;
        p.w0 = merge(p.w0, d0, l0);
        p.w1 = merge(p.w1, d1, l1);
        model[a] = p;
    endtask

    task automatic collect(dsio_addr_t a);
        dsio_pair_t e;
        e = model[a];
        for (int n = 0; n < 40; n++) begin
            if (u_dsio_ctl_model.words.size() >= 2) break;
            @(posedge clock);
        end
        // extra settle time shows a stray or refused burst leaking out
        repeat (20) @(posedge clock);
        `CHK(u_dsio_ctl_model.words.size(), 2, "burst size");
        if (u_dsio_ctl_model.words.size() >= 2) begin
            `CHK(u_dsio_ctl_model.words[0], e.w0, "word0");
            `CHK(u_dsio_ctl_model.words[1], e.w1, "word1");
        end
        u_dsio_ctl_model.words.delete();
    endtask

    // a second read in the very next cycle must be refused
    task automatic rd(dsio_addr_t a);
        step();
        `CHK(read_ready, 1'b1, "ready idle");
        access_request_n = 1'b0;
        direction_select = 1'b1;
        address = a;
        step();
        `CHK(read_ready, 1'b0, "ready after read");
        address = a + 19'h1;
        step();
        access_request_n = 1'b1;
        collect(a);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        `CHK(read_data_oe, 1'b0, "oe after reset");
        repeat (20) step();
        `CHK(u_dsio_ctl_model.words.size(), 0, "idle words");
    endtask

    task automatic t_full();
        wr(19'h00010, 36'h123456789, 36'hfedcba987, 4'h0, 4'h0);
        wr(19'h7ffff, 36'h0a5a5a5a5, 36'h5a5a5a5a5, 4'h0, 4'h0);
        rd(19'h00010);
        wr(19'h00011, 36'h111111111, 36'h222222222, 4'h0, 4'h0);
        rd(19'h00010);
        rd(19'h7ffff);
    endtask

    task automatic t_lanes();
        dsio_lanes_t l0, l1;
        for (int i = 0; i < `DSIO_LANES; i++) begin
            l0 = ~(4'h1 << i);
            l1 = ~(4'h1 << ((i + 1) % `DSIO_LANES));
            wr(19'h00020 + i, 36'h0, 36'h0, 4'h0, 4'h0);
            wr(19'h00020 + i, 36'hfffffffff, 36'hfffffffff, l0, l1);
            rd(19'h00020 + i);
        end
        wr(19'h00020, 36'h0, 36'h0, 4'hf, 4'hf);
        rd(19'h00020);
        wr(19'h00021, 36'h0, 36'hfffffffff, 4'hc, 4'h3);
        rd(19'h00021);
    endtask

    task automatic t_nop();
        step();
        access_request_n = 1'b1;
        direction_select = 1'b1;
        for (int i = 0; i < 10; i++) begin
            step();
            address = 19'h00010 + i;
        end
        repeat (20) step();
        `CHK(u_dsio_ctl_model.words.size(), 0, "nop words");
    endtask

    task automatic t_stop();
        step();
        access_request_n = 1'b0;
        direction_select = 1'b1;
        address = 19'h00011;
        step();
        access_request_n = 1'b1;
        clock_en = 1'b0;
        park = 1'b1;
        repeat (15) step();
        `CHK(u_dsio_ctl_model.words.size(), 0, "frozen words");
        `CHK(read_data_oe, 1'b0, "frozen oe");
        clock_en = 1'b1;
        park = 1'b0;
        collect(19'h00011);
    endtask

    task automatic t_latency();
        step();
        pll_bypass_n = 1'b0;
        repeat (10) step();
        rd(19'h7ffff);
        pll_bypass_n = 1'b1;
        repeat (10) step();
    endtask

    // c parked high through a second reset: single clock for good
    task automatic t_single();
        park = 1'b1;
        rst = 1'b1;
        repeat (8) step();
        rst = 1'b0;
        step();
        `CHK(read_data_oe, 1'b0, "oe after strap");
        wr(19'h00030, 36'h13579bdf0, 36'h2468ace13, 4'h0, 4'h0);
        rd(19'h00030);
    endtask

    task automatic end_of_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        clock_en = 1'b1;
        pll_bypass_n = 1'b1;
        park = 1'b0;
        access_request_n = 1'b1;
        direction_select = 1'b0;
        address = 19'h0;
        byte_lane_enable_n = 4'hf;
        write_data = 36'h0;
        repeat (8) @(posedge clock);
        #1;
        rst = 1'b0;
        t_reset();
        t_full();
        t_lanes();
        t_nop();
        t_stop();
        t_latency();
        t_single();
        end_of_test();
    end
endmodule
